// ==== hw/wtc_pkg.sv ====
// Package with register map, field layout and encodings of the watchpoint trace control block
package wtc_pkg;
  localparam logic [3:0] off_ctrl_a      = 4'h0;
  localparam logic [3:0] off_ctrl_b      = 4'h1;
  localparam logic [3:0] off_addr_a      = 4'h2;
  localparam logic [3:0] off_addr_b      = 4'h3;
  localparam logic [3:0] off_data_a      = 4'h4;
  localparam logic [3:0] off_data_b      = 4'h5;
  localparam logic [3:0] off_trigger     = 4'h6;
  localparam logic [3:0] off_dev_ctrl    = 4'h7;
  localparam logic [3:0] off_status      = 4'h8;
  localparam int en_hi = 31;
  localparam int en_lo = 30;
  localparam int dir_hi = 29;
  localparam int dir_lo = 28;
  localparam int mask_hi = 23;
  localparam int mask_lo = 20;
  localparam int opa_bit = 17;
  localparam int opd_bit = 16;
  localparam int size_hi = 11;
  localparam int size_lo = 9;
  localparam int asid_hi = 8;
  localparam int asid_lo = 1;
  localparam int asid_en_bit = 0;
  localparam logic [31:0] ctrl_wmask = 32'hf0f3_0fff;
  localparam logic [31:0] trig_wmask = 32'hfff0_0000;
  localparam int pts_lo = 29;
  localparam int pte_lo = 26;
  localparam int dts_lo = 23;
  localparam int dte_lo = 20;
  localparam int tm_prog_bit = 2;
  localparam logic [1:0] en_off = 2'h0;
  localparam logic [1:0] en_break = 2'h1;
  localparam logic [1:0] en_watch = 2'h3;
  localparam logic [1:0] dir_read = 2'h0;
  localparam logic [1:0] dir_write = 2'h1;
  localparam logic [1:0] dir_any = 2'h2;
  localparam logic [2:0] sel_data_a = 3'h6;
  localparam logic [2:0] sel_data_b = 3'h7;
  localparam logic [2:0] size_byte = 3'h4;
  localparam logic [2:0] size_half = 3'h5;
  localparam logic [2:0] size_word = 3'h6;
  localparam logic [1:0] acc_byte = 2'h0;
  localparam logic [1:0] acc_half = 2'h1;
  localparam logic [1:0] acc_word = 2'h2;
  localparam logic [7:0] bytes_compact = 8'h02;
  localparam logic [7:0] bytes_extended = 8'h04;
  localparam logic [5:0] code_direct = 6'h03;
  localparam logic [5:0] code_indirect = 6'h04;
  localparam logic [5:0] code_sync = 6'h09;
  localparam logic [5:0] code_full = 6'h1b;
  localparam logic [5:0] code_corr = 6'h21;
  localparam logic [5:0] code_indirect_sync = 6'h0c;
  localparam logic [5:0] code_direct_sync = 6'h0b;
  localparam logic [1:0] full_count = 2'h1;
  localparam logic [1:0] full_buffer = 2'h2;
  localparam logic [1:0] corr_debug = 2'h0;
  localparam logic [1:0] corr_disable = 2'h1;
  localparam logic [1:0] corr_sleep = 2'h2;
endpackage

// ==== hw/data_watch_unit.sv ====
// One data watch comparator unit
`timescale 1ns/1ps
`default_nettype none
module data_watch_unit (
  input  wire logic [31:0] ctrl,
  input  wire logic [31:0] waddr,
  input  wire logic [31:0] wdata,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_size,
  input  wire logic [31:0] acc_addr,
  input  wire logic [31:0] acc_data,
  input  wire logic [7:0]  cur_asid,
  output logic             watch_hit,
  output logic             break_hit
);
  wire [1:0] en    = ctrl[wtc_pkg::en_hi:wtc_pkg::en_lo];
  wire [1:0] dir   = ctrl[wtc_pkg::dir_hi:wtc_pkg::dir_lo];
  wire [3:0] bmask = ctrl[wtc_pkg::mask_hi:wtc_pkg::mask_lo];
  wire [2:0] sz    = ctrl[wtc_pkg::size_hi:wtc_pkg::size_lo];
  wire dir_ok = (dir == wtc_pkg::dir_read && !acc_write) ||
                (dir == wtc_pkg::dir_write && acc_write) || (dir == wtc_pkg::dir_any);
  wire size_ok = !sz[2] || (sz == wtc_pkg::size_byte && acc_size == wtc_pkg::acc_byte) ||
                 (sz == wtc_pkg::size_half && acc_size == wtc_pkg::acc_half) ||
                 (sz == wtc_pkg::size_word && acc_size == wtc_pkg::acc_word);
  logic [3:0] lane_ok;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : lanes
      assign lane_ok[g] = bmask[g] || (acc_data[g*8+:8] == wdata[g*8+:8]);
    end
  endgenerate
  wire addr_ok = !ctrl[wtc_pkg::opa_bit] || (acc_addr == waddr);
  wire data_ok = !ctrl[wtc_pkg::opd_bit] || (&lane_ok);
  wire asid_ok = !ctrl[wtc_pkg::asid_en_bit] || (cur_asid == ctrl[wtc_pkg::asid_hi:wtc_pkg::asid_lo]);
  wire match = acc_valid && dir_ok && size_ok && addr_ok && data_ok && asid_ok;
  assign watch_hit = match && (en == wtc_pkg::en_watch);
  assign break_hit = match && (en == wtc_pkg::en_break);
endmodule
`default_nettype wire

// ==== hw/watchpoint_trace_control.sv ====
// Watchpoint matching, trace triggers and program flow trace message generation
//
// Summary of operation
// - Enable field: off, breakpoint, reserved, watchpoint
// - Direction: read, write, any, reserved
// - Mask bits exclude data byte lanes
// - Operand bits enable address and data compare
// - Size field requires byte, half or word
// - Optional address space identifier match
// - Program trace start watchpoint select
// - Program trace end watchpoint select
// - Data trace start and end selects
// - Program trace needs trace mode bit two
// - Indirect message carries count and target
// - Sync message after start or lost sync
// - Taken branch turns sync into branch-sync
// - Resource full message on overflow
// - Correlation on disable, debug, sleep entry
// - No program trace inside debug mode
// - Sync message on debug mode exit
// - Count adds two or four bytes
// - Taken traced indirect branch not counted
// - Only executed instructions are counted
// - Counter cleared on every program message
// - Unique address is xor with last
// - Direct branch: 8-bit count, code 3
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module watchpoint_trace_control (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic [5:0]  prog_wp_hit,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_size,
  input  wire logic [31:0] acc_addr,
  input  wire logic [31:0] acc_data,
  input  wire logic [7:0]  cur_asid,
  input  wire logic        retire_valid,
  input  wire logic        retire_extended,
  input  wire logic        retire_direct_taken,
  input  wire logic        retire_indirect_taken,
  input  wire logic [1:0]  retire_event_id,
  input  wire logic [31:0] retire_target,
  input  wire logic [31:0] retire_pc,
  input  wire logic        debug_mode,
  input  wire logic        sleep_enter,
  input  wire logic        buffer_overflow,
  output logic             data_break,
  output logic             data_trace_on,
  output logic             msg_valid,
  output logic [5:0]       msg_code,
  output logic [7:0]       msg_count,
  output logic [31:0]      msg_addr,
  output logic [1:0]       msg_event
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_a_reg;
  logic [31:0] ctrl_b_reg;
  logic [31:0] addr_a_reg;
  logic [31:0] addr_b_reg;
  logic [31:0] data_a_reg;
  logic [31:0] data_b_reg;
  logic [31:0] trig_reg;
  logic [2:0]  dev_ctrl_reg;
  logic        prog_on_reg;
  logic        data_on_reg;
  logic        need_sync_reg;
  logic        debug_reg;
  logic [7:0]  count_reg;
  logic [7:0]  count_next;
  logic [31:0] last_addr_reg;

  function automatic logic sel_hit(input logic [2:0] sel, input logic [7:0] hits);
    sel_hit = (sel != 3'h0) && hits[sel];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire wa;
  wire wb;
  wire ba;
  wire bb;
  data_watch_unit unit_a (
    .ctrl      (ctrl_a_reg),
    .waddr     (addr_a_reg),
    .wdata     (data_a_reg),
    .acc_valid (acc_valid),
    .acc_write (acc_write),
    .acc_size  (acc_size),
    .acc_addr  (acc_addr),
    .acc_data  (acc_data),
    .cur_asid  (cur_asid),
    .watch_hit (wa),
    .break_hit (ba)
  );
  data_watch_unit unit_b (
    .ctrl      (ctrl_b_reg),
    .waddr     (addr_b_reg),
    .wdata     (data_b_reg),
    .acc_valid (acc_valid),
    .acc_write (acc_write),
    .acc_size  (acc_size),
    .acc_addr  (acc_addr),
    .acc_data  (acc_data),
    .cur_asid  (cur_asid),
    .watch_hit (wb),
    .break_hit (bb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Hit vector indexed by the trigger select codes 1..7
  wire [7:0] hits = {wb, wa, prog_wp_hit[5:1], 1'b0};
  wire pts_hit = sel_hit(trig_reg[wtc_pkg::pts_lo+:3], hits);
  wire pte_hit = sel_hit(trig_reg[wtc_pkg::pte_lo+:3], hits);
  wire dts_hit = sel_hit(trig_reg[wtc_pkg::dts_lo+:3], hits);
  wire dte_hit = sel_hit(trig_reg[wtc_pkg::dte_lo+:3], hits);
  wire trig_used = trig_reg[wtc_pkg::pts_lo+:3] != 3'h0;
  wire tm_en = dev_ctrl_reg[wtc_pkg::tm_prog_bit];
  wire prog_on_next = tm_en && (trig_used ? ((prog_on_reg || pts_hit) && !pte_hit) : 1'b1);
  wire start_evt = prog_on_next && !prog_on_reg;
  wire stop_evt = prog_on_reg && !prog_on_next;
  wire dbg_enter = debug_mode && !debug_reg;
  wire dbg_exit = !debug_mode && debug_reg;
  wire tracing = prog_on_reg && !debug_mode;
  wire exec = retire_valid && tracing;
  wire [7:0] step = retire_extended ? wtc_pkg::bytes_extended : wtc_pkg::bytes_compact;
  wire taken = exec && (retire_direct_taken || retire_indirect_taken);
  wire count_ovf = exec && !retire_indirect_taken && ({1'b0, count_reg} + {1'b0, step} > 9'h0ff);
  wire sync_cond = (need_sync_reg || dbg_exit) && tracing;
  wire [31:0] uaddr = last_addr_reg ^ retire_target;

  ////////////////////////////////////////////////////////////////////////////
  logic       emit;
  logic [5:0] code_sel;
  logic [31:0] addr_sel;
  logic [1:0] evt_sel;
  logic       addr_sent;
  always_comb begin
    emit = 1'b1;
    code_sel = wtc_pkg::code_sync;
    addr_sel = retire_pc;
    evt_sel = 2'h0;
    addr_sent = 1'b0;
    if (dbg_enter && prog_on_reg) begin
      code_sel = wtc_pkg::code_corr;
      evt_sel = wtc_pkg::corr_debug;
    end else if (stop_evt || (sleep_enter && tracing)) begin
      code_sel = wtc_pkg::code_corr;
      evt_sel = sleep_enter ? wtc_pkg::corr_sleep : wtc_pkg::corr_disable;
    end else if (sync_cond && taken) begin
      code_sel = retire_indirect_taken ? wtc_pkg::code_indirect_sync : wtc_pkg::code_direct_sync;
      addr_sel = retire_target;
      evt_sel = retire_event_id;
      addr_sent = 1'b1;
    end else if (sync_cond) begin
      addr_sent = 1'b1;
    end else if (exec && retire_indirect_taken) begin
      code_sel = wtc_pkg::code_indirect;
      addr_sel = uaddr;
      evt_sel = retire_event_id;
      addr_sent = 1'b1;
    end else if (exec && retire_direct_taken) begin
      code_sel = wtc_pkg::code_direct;
    end else if ((buffer_overflow && tracing) || count_ovf) begin
      code_sel = wtc_pkg::code_full;
      evt_sel = count_ovf ? wtc_pkg::full_count : wtc_pkg::full_buffer;
    end else begin
      emit = 1'b0;
    end
  end

  // Counted bytes; traced taken indirect branches excluded
  wire [7:0] add_bytes = (exec && !(retire_indirect_taken && emit)) ? step : 8'h00;
  // Correlation and count overflow report the old count; current bytes carry on
  wire keep_cur = (code_sel == wtc_pkg::code_corr) || (count_ovf && code_sel == wtc_pkg::code_full);
  always_comb begin
    if (emit) begin
      count_next = keep_cur ? add_bytes : 8'h00;
    end else begin
      count_next = count_reg + add_bytes;
    end
  end
  wire [7:0] count_out = keep_cur ? count_reg : count_reg + add_bytes;

  ////////////////////////////////////////////////////////////////////////////
  wire wr_a  = reg_wr && reg_addr == wtc_pkg::off_ctrl_a;
  wire wr_b  = reg_wr && reg_addr == wtc_pkg::off_ctrl_b;
  wire wr_aa = reg_wr && reg_addr == wtc_pkg::off_addr_a;
  wire wr_ab = reg_wr && reg_addr == wtc_pkg::off_addr_b;
  wire wr_da = reg_wr && reg_addr == wtc_pkg::off_data_a;
  wire wr_db = reg_wr && reg_addr == wtc_pkg::off_data_b;
  wire wr_t  = reg_wr && reg_addr == wtc_pkg::off_trigger;
  wire wr_dc = reg_wr && reg_addr == wtc_pkg::off_dev_ctrl;
  wire [31:0] status_word = {26'h0, debug_reg, need_sync_reg, data_on_reg, prog_on_reg, wb, wa};
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      wtc_pkg::off_ctrl_a:   rd_mux = ctrl_a_reg;
      wtc_pkg::off_ctrl_b:   rd_mux = ctrl_b_reg;
      wtc_pkg::off_addr_a:   rd_mux = addr_a_reg;
      wtc_pkg::off_addr_b:   rd_mux = addr_b_reg;
      wtc_pkg::off_data_a:   rd_mux = data_a_reg;
      wtc_pkg::off_data_b:   rd_mux = data_b_reg;
      wtc_pkg::off_trigger:  rd_mux = trig_reg;
      wtc_pkg::off_dev_ctrl: rd_mux = {29'h0, dev_ctrl_reg};
      wtc_pkg::off_status:   rd_mux = status_word;
      default:               rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg <= 32'h0;
      ctrl_b_reg <= 32'h0;
      addr_a_reg <= 32'h0;
      addr_b_reg <= 32'h0;
      data_a_reg <= 32'h0;
      data_b_reg <= 32'h0;
      trig_reg <= 32'h0;
      dev_ctrl_reg <= 3'h0;
      reg_rdata <= 32'h0;
    end else if (ce) begin
      if (wr_a) ctrl_a_reg <= reg_wdata & wtc_pkg::ctrl_wmask;
      if (wr_b) ctrl_b_reg <= reg_wdata & wtc_pkg::ctrl_wmask;
      if (wr_aa) addr_a_reg <= reg_wdata;
      if (wr_ab) addr_b_reg <= reg_wdata;
      if (wr_da) data_a_reg <= reg_wdata;
      if (wr_db) data_b_reg <= reg_wdata;
      if (wr_t) trig_reg <= reg_wdata & wtc_pkg::trig_wmask;
      if (wr_dc) dev_ctrl_reg <= reg_wdata[2:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_on_reg <= 1'b0;
      data_on_reg <= 1'b0;
      need_sync_reg <= 1'b1;
      debug_reg <= 1'b0;
      count_reg <= 8'h0;
      last_addr_reg <= 32'h0;
    end else if (ce) begin
      prog_on_reg <= prog_on_next;
      debug_reg <= debug_mode;
      data_on_reg <= (data_on_reg || dts_hit) && !dte_hit;
      if (start_evt || (buffer_overflow && tracing)) begin
        need_sync_reg <= 1'b1;
      end else if (sync_cond && emit && code_sel != wtc_pkg::code_corr) begin
        need_sync_reg <= 1'b0;
      end else if (dbg_exit) begin
        need_sync_reg <= 1'b1;
      end
      count_reg <= count_next;
      if (emit && addr_sent) last_addr_reg <= (code_sel == wtc_pkg::code_indirect) ? retire_target : addr_sel;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      msg_valid <= 1'b0;
      msg_code <= 6'h0;
      msg_count <= 8'h0;
      msg_addr <= 32'h0;
      msg_event <= 2'h0;
      data_break <= 1'b0;
    end else if (ce) begin
      msg_valid <= emit;
      data_break <= ba || bb;
      if (emit) begin
        msg_code <= code_sel;
        msg_count <= count_out;
        msg_addr <= addr_sel;
        msg_event <= evt_sel;
      end
    end
  end

  assign data_trace_on = data_on_reg;
endmodule
`default_nettype wire

// ==== test/wtc_sva.sv ====
// Assertions on the ports of the watchpoint trace control block
`timescale 1ns/1ps
`default_nettype none
module wtc_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        acc_valid,
  input wire logic        retire_valid,
  input wire logic        retire_direct_taken,
  input wire logic        retire_indirect_taken,
  input wire logic [1:0]  retire_event_id,
  input wire logic        debug_mode,
  input wire logic        data_break,
  input wire logic        msg_valid,
  input wire logic [5:0]  msg_code,
  input wire logic [7:0]  msg_count,
  input wire logic [1:0]  msg_event
);
  logic tm_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Trace mode bit as last written by the debugger
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) tm_reg <= 1'b0;
    else if (reg_wr && reg_addr == wtc_pkg::off_dev_ctrl) tm_reg <= reg_wdata[wtc_pkg::tm_prog_bit];
  end
  ////////////////////////////////////////////////////////////////
  a_trace_gate: assert property (msg_valid |-> $past(tm_reg) ||
    (msg_code == wtc_pkg::code_corr && $past(tm_reg, 2)))
    else $error("message while trace mode off");
  a_debug_quiet: assert property (debug_mode && $past(debug_mode) |=> !msg_valid)
    else $error("message inside debug mode");
  a_count_even: assert property (msg_valid |-> !msg_count[0])
    else $error("odd byte count");
  a_break_cause: assert property (data_break |-> $past(acc_valid))
    else $error("break without access");
  a_indirect_cause: assert property (msg_valid && msg_code == wtc_pkg::code_indirect |->
    $past(retire_valid && retire_indirect_taken))
    else $error("indirect message without taken indirect");
  a_indirect_event: assert property (msg_valid && msg_code == wtc_pkg::code_indirect |->
    msg_event == $past(retire_event_id))
    else $error("indirect event id wrong");
  a_direct_cause: assert property (msg_valid && msg_code == wtc_pkg::code_direct |->
    $past(retire_valid && retire_direct_taken))
    else $error("direct message without taken direct");
  a_exit_sync: assert property ($fell(debug_mode) && retire_valid && retire_indirect_taken && tm_reg |=>
    msg_valid && msg_code == wtc_pkg::code_indirect_sync)
    else $error("no sync on debug exit");
endmodule
bind watchpoint_trace_control wtc_sva chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .acc_valid(acc_valid), .retire_valid(retire_valid), .retire_direct_taken(retire_direct_taken),
  .retire_indirect_taken(retire_indirect_taken), .retire_event_id(retire_event_id), .debug_mode(debug_mode),
  .data_break(data_break), .msg_valid(msg_valid), .msg_code(msg_code), .msg_count(msg_count),
  .msg_event(msg_event));
`default_nettype wire

// ==== test/trace_tool_model.sv ====
// Debug tool model that rebuilds branch targets from trace messages
`timescale 1ns/1ps
`default_nettype none
module trace_tool_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        msg_valid,
  input  wire logic [5:0]  msg_code,
  input  wire logic [31:0] msg_addr,
  output logic [31:0]      target_seen,
  output int               n_msgs
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      target_seen <= 32'h0;
      n_msgs <= 0;
    end else if (msg_valid) begin
      n_msgs <= n_msgs + 1;
      if (msg_code == wtc_pkg::code_indirect) target_seen <= target_seen ^ msg_addr;
      else if (msg_code == wtc_pkg::code_sync || msg_code == wtc_pkg::code_indirect_sync) target_seen <= msg_addr;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking testbench of the watchpoint trace control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk, rst, ce, reg_wr, reg_rd, acc_valid, acc_write, retire_valid, retire_extended;
  logic        retire_direct_taken, retire_indirect_taken, debug_mode, sleep_enter, buffer_overflow;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, acc_addr, acc_data, retire_target, retire_pc, t_last, t_new;
  logic [5:0]  prog_wp_hit;
  logic [1:0]  acc_size, retire_event_id, ev;
  logic [7:0]  cur_asid, bytes;
  wire logic [31:0] reg_rdata, msg_addr, target_seen;
  wire logic        data_break, data_trace_on, msg_valid;
  wire logic [5:0]  msg_code;
  wire logic [7:0]  msg_count;
  wire logic [1:0]  msg_event;
  logic [31:0] rdq[$], ctl[15];
  logic [47:0] mq[$], mm[$], m;
  logic        bq[$], rd_seen, acc_seen;
  int          n_errors, comparisons, cycles, n_msgs;
  localparam logic [31:0] wa = 32'h1000_0040;
  localparam logic [31:0] wd = 32'h1234_5678;
  localparam logic [47:0] m_ce = {6'h3f, 8'h0, 32'h0, 2'h3};
  localparam logic [47:0] m_ca = {6'h3f, 8'hff, 32'hffff_ffff, 2'h0};
  watchpoint_trace_control uut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_wp_hit(prog_wp_hit), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_size(acc_size), .acc_addr(acc_addr), .acc_data(acc_data), .cur_asid(cur_asid),
    .retire_valid(retire_valid), .retire_extended(retire_extended), .retire_direct_taken(retire_direct_taken),
    .retire_indirect_taken(retire_indirect_taken), .retire_event_id(retire_event_id),
    .retire_target(retire_target), .retire_pc(retire_pc), .debug_mode(debug_mode), .sleep_enter(sleep_enter),
    .buffer_overflow(buffer_overflow), .data_break(data_break), .data_trace_on(data_trace_on),
    .msg_valid(msg_valid), .msg_code(msg_code), .msg_count(msg_count), .msg_addr(msg_addr), .msg_event(msg_event));
  trace_tool_model tool (.mclk(mclk), .rst(rst), .msg_valid(msg_valid), .msg_code(msg_code), .msg_addr(msg_addr),
    .target_seen(target_seen), .n_msgs(n_msgs));
  ////////////////////////////////////////////////////////////////
  // Bus, access and retire drivers
  task automatic tick(int n = 1); repeat (n) @(posedge mclk); endtask
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; tick(); reg_wr <= 1'b0; tick();
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    rdq.push_back(e); reg_addr <= a; reg_rd <= 1'b1; tick(); reg_rd <= 1'b0; tick();
  endtask
  task automatic acc(logic w, logic [31:0] a, logic [31:0] d, logic [7:0] s, logic e);
    bq.push_back(e); acc_write <= w; acc_addr <= a; acc_data <= d; cur_asid <= s; acc_valid <= 1'b1;
    tick(); acc_valid <= 1'b0; tick();
  endtask
  task automatic rt(logic x, logic dt, logic it, logic [1:0] e, logic [31:0] t);
    retire_extended <= x; retire_direct_taken <= dt; retire_indirect_taken <= it; retire_event_id <= e;
    retire_target <= t; retire_pc <= $urandom; retire_valid <= 1'b1; tick(); retire_valid <= 1'b0; tick();
  endtask
  task automatic ex(logic [5:0] c, logic [7:0] n, logic [31:0] a, logic [1:0] e, logic [47:0] k);
    mq.push_back({c, n, a, e}); mm.push_back(k);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d messages %0d", comparisons, n_errors, n_msgs);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock, timeout and result monitor
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rd_seen <= reg_rd; acc_seen <= acc_valid; cycles++;
    if (cycles == 20000) begin n_errors++; stop_test(); end
  end
  always @(negedge mclk) if (!rst) begin
    if (rd_seen) check("reg_rdata", rdq.pop_front(), reg_rdata);
    if (acc_seen) check("data_break", bq.pop_front(), data_break);
    if (msg_valid && mq.size() == 0) check("msg_valid", 48'h0, 48'h1);
    else if (msg_valid) begin
      m = mm.pop_front();
      check("message", mq.pop_front() & m, {msg_code, msg_count, msg_addr, msg_event} & m);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ce} = 2'b11; {reg_wr, reg_rd, acc_valid, acc_write, retire_valid, retire_extended} = '0;
    {retire_direct_taken, retire_indirect_taken, debug_mode, sleep_enter, buffer_overflow} = '0;
    {reg_addr, reg_wdata, acc_addr, acc_data, retire_target, retire_pc, prog_wp_hit} = '0;
    {retire_event_id, cur_asid, rd_seen, acc_seen} = '0; acc_size = wtc_pkg::acc_word;
    void'($urandom(66821));
    ctl = '{32'h4002_0000, 32'h0002_0000, 32'h8002_0000, 32'hc002_0000, 32'h5002_0000, 32'h6002_0000,
      32'h7002_0000, 32'h4081_0000, 32'h4011_0000, 32'h4002_0800, 32'h4002_0c00, 32'h4002_0e00,
      32'h4002_00b5, 32'h4002_00b5, 32'h4002_0000};
    tick(10); rst <= 1'b0; tick();
    rd(wtc_pkg::off_ctrl_a, 32'h0); rd(wtc_pkg::off_trigger, 32'h0); rd(wtc_pkg::off_status, 32'h10);
    wr(wtc_pkg::off_ctrl_a, '1); rd(wtc_pkg::off_ctrl_a, wtc_pkg::ctrl_wmask);
    wr(wtc_pkg::off_trigger, '1); rd(wtc_pkg::off_trigger, wtc_pkg::trig_wmask);
    wr(4'hf, '1); rd(4'hf, 32'h0);
    ce <= 1'b0; wr(wtc_pkg::off_data_b, '1); ce <= 1'b1; rd(wtc_pkg::off_data_b, 32'h0);
    $display("test registers done");
    wr(wtc_pkg::off_addr_a, wa); wr(wtc_pkg::off_data_a, wd); wr(wtc_pkg::off_trigger, 32'h0);
    for (int i = 0; i < 15; i++) begin
      wr(wtc_pkg::off_ctrl_a, ctl[i]);
      acc(i inside {5, 6}, wa + (i == 14 ? 32'h4 : 32'h0), wd ^ (i inside {7, 8} ? 32'h5500_0000 : 32'h0),
        i == 13 ? 8'h5b : 8'h5a, i inside {0, 5, 7, 10, 12});
    end
    $display("test watch matching done");
    wr(wtc_pkg::off_ctrl_a, 32'hc002_0000); wr(wtc_pkg::off_ctrl_b, 32'hc002_0000);
    wr(wtc_pkg::off_addr_b, wa + 32'h100); wr(wtc_pkg::off_trigger, 32'h03e0_0000);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, wa + (i == 1 ? 32'h100 : 32'h0), wd, 8'h0, 1'b0);
      tick(2); check("data_trace_on", 48'(i == 1), 48'(data_trace_on));
    end
    $display("test data trace done");
    wr(wtc_pkg::off_dev_ctrl, 32'h4);
    ev = 2'($urandom); t_last = $urandom; ex(wtc_pkg::code_indirect_sync, 8'h0, t_last, 2'h0, m_ca);
    rt(1'b0, 1'b0, 1'b1, ev, t_last);
    for (int k = 0; k < 3; k++) begin
      repeat ($urandom_range(1, 8)) begin
        retire_extended <= 1'($urandom);
        tick();
      end
      bytes = 8'h0;
      for (int j = $urandom_range(1, 60); j > 0; j--) begin
        rt(j[0], 1'b0, 1'b0, 2'h0, $urandom);
        bytes += j[0] ? wtc_pkg::bytes_extended : wtc_pkg::bytes_compact;
      end
      ev = 2'($urandom); t_new = $urandom;
      ex(wtc_pkg::code_indirect, bytes, t_new ^ t_last, ev, '1);
      rt(1'b1, 1'b0, 1'b1, ev, t_new); tick(); check("target_seen", 48'(t_new), 48'(target_seen));
      t_last = t_new;
    end
    ex(wtc_pkg::code_direct, wtc_pkg::bytes_compact, 32'h0, 2'h0, {6'h3f, 8'hff, 34'h0});
    rt(1'b0, 1'b1, 1'b0, 2'h0, 32'h0);
    $display("test branch messages done");
    t_new = $urandom; retire_pc <= t_new;
    ex(wtc_pkg::code_full, 8'h0, 32'h0, wtc_pkg::full_buffer, {6'h3f, 8'hff, 32'h0, 2'h3});
    buffer_overflow <= 1'b1; tick(); buffer_overflow <= 1'b0; tick();
    ex(wtc_pkg::code_sync, 8'h0, t_new, 2'h0, m_ca);
    t_last = $urandom; ex(wtc_pkg::code_indirect, 8'h0, t_new ^ t_last, 2'h1, '1);
    rt(1'b0, 1'b0, 1'b1, 2'h1, t_last);
    ex(wtc_pkg::code_corr, 8'h0, 32'h0, wtc_pkg::corr_debug, m_ce);
    debug_mode <= 1'b1; tick(2); rt(1'b0, 1'b0, 1'b1, 2'h2, $urandom);
    t_new = $urandom; ex(wtc_pkg::code_indirect_sync, 8'h0, t_new, 2'h0, {6'h3f, 8'h0, 32'hffff_ffff, 2'h0});
    debug_mode <= 1'b0; rt(1'b0, 1'b0, 1'b1, 2'h0, t_new);
    ex(wtc_pkg::code_corr, 8'h0, 32'h0, wtc_pkg::corr_sleep, m_ce);
    sleep_enter <= 1'b1; tick(); sleep_enter <= 1'b0; tick();
    ex(wtc_pkg::code_corr, 8'h0, 32'h0, wtc_pkg::corr_disable, m_ce); wr(wtc_pkg::off_dev_ctrl, 32'h0);
    rt(1'b0, 1'b0, 1'b1, 2'h0, $urandom); tick(4);
    wr(wtc_pkg::off_trigger, 32'h2800_0000); wr(wtc_pkg::off_dev_ctrl, 32'h4); tick(4);
    ex(wtc_pkg::code_sync, 8'h0, 32'h0, 2'h0, {6'h3f, 42'h0});
    prog_wp_hit <= 6'h02; tick(); prog_wp_hit <= 6'h00; tick(2);
    ex(wtc_pkg::code_corr, 8'h0, 32'h0, wtc_pkg::corr_disable, m_ce);
    prog_wp_hit <= 6'h04; tick(); prog_wp_hit <= 6'h00; tick(2);
    check("pending messages", 48'h0, 48'(mq.size()));
    $display("test events done");
    stop_test();
  end
endmodule
`default_nettype wire
